/* File: rtl/peq_pkg.sv */
// Constants, register map and types for the pulse, edge and quadrature counter.
// Assumes a 50 MHz system clock and an AXI4-Lite register port with 32-bit data.
//
// Functional notes
// - Switch-closure inputs are debounced so one closure gives exactly one count.
// - Debounce hold time makes switch-closure maximum rate lower than high-frequency mode.
// - Quadrature count rises while channel A leads channel B (clockwise).
// - Quadrature count falls while channel B leads channel A (counterclockwise).
// - Decoder gives net count, net direction, and separate forward and reverse totals.
// - Mode one: up on A rising when A leads, down on A falling when B leads.
// - Mode two: count on both edges of A only, direction from lead.
// - Mode three: count every edge of both channels, direction from lead.
// - Each input has its own 32-bit counter accumulating over the scan interval.
// - Counters are sampled at each scan start and then cleared.
// - A counter wraps, giving a wrong result, when counts exceed its capacity.
// - Counter resolution is one count per scan interval.
// - Single-edge timing measures one transition time, giving time, frequency or period.
// - Multi-edge timing: between edges, from previous terminal, spanning scan intervals.
// - Edge timing returns not-a-number on timer expiry, or on too-fast input in period and previous-terminal modes only.
// - Universal terminals pair up adjacently, each pair decoding one encoder.
package peq_pkg;
	localparam int ADDR_W = 8;
	localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
	localparam logic [ADDR_W-1:0] REG_SCAN_PERIOD = 8'h04;
	localparam logic [ADDR_W-1:0] REG_SW_MASK = 8'h08;
	localparam logic [ADDR_W-1:0] REG_QUAD_EN = 8'h0C;
	localparam logic [ADDR_W-1:0] REG_QUAD_MODE = 8'h10;
	localparam logic [ADDR_W-1:0] REG_IRQ_STAT = 8'h14;
	localparam logic [ADDR_W-1:0] REG_IRQ_CLR = 8'h18;
	localparam logic [ADDR_W-1:0] REG_IRQ_EN = 8'h1C;
	localparam logic [ADDR_W-1:0] REG_TMR_CFG = 8'h20;
	localparam logic [ADDR_W-1:0] REG_TMR_TIMEOUT = 8'h24;
	localparam logic [ADDR_W-1:0] REG_TMR_RESULT = 8'h28;
	localparam logic [ADDR_W-1:0] REG_TMR_STAT = 8'h2C;
	localparam logic [ADDR_W-1:0] REG_SCAN_CNT = 8'h30;
	localparam logic [ADDR_W-1:0] REG_PULSE_BASE = 8'h40;
	localparam logic [ADDR_W-1:0] REG_QUAD_BASE = 8'h80;
	localparam int QUAD_STRIDE = 16;
	localparam int QW_NET = 0;
	localparam int QW_FWD = 1;
	localparam int QW_REV = 2;
	localparam int QW_DIR = 3;
	localparam int CTRL_EN_BIT = 0;
	localparam int CTRL_TSTART_BIT = 1;
	localparam int IRQ_W = 4;
	localparam int IRQ_SCAN = 0;
	localparam int IRQ_TDONE = 1;
	localparam int IRQ_TNAN = 2;
	localparam int IRQ_WRAP = 3;
	localparam int TCFG_SEL_LSB = 0;
	localparam int TCFG_SEL_W = 4;
	localparam int TCFG_MODE_LSB = 4;
	localparam int TSTAT_BUSY = 0;
	localparam int TSTAT_NAN = 1;
	localparam int TSTAT_VALID = 2;
	localparam logic [31:0] SCAN_PERIOD_RST = 32'h02FAF080;
	localparam logic [31:0] TMR_TIMEOUT_RST = 32'h00989680;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam int CLK_PERIOD_NS = 20;
	localparam int DEBOUNCE_NS = 1000000;
	localparam int DEBOUNCE_CYC = (DEBOUNCE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int MIN_EDGE_NS = 100;
	localparam int MIN_EDGE_CYC = (MIN_EDGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	typedef enum logic [1:0] {
		QM_A_RISE = 2'b00,
		QM_A_BOTH = 2'b01,
		QM_ALL = 2'b10
	} peq_qmode_t;
	typedef enum logic [1:0] {
		TM_SINGLE = 2'b00,
		TM_PERIOD = 2'b01,
		TM_PREV = 2'b10
	} peq_tmode_t;
	typedef enum logic [1:0] {
		TS_IDLE = 2'b00,
		TS_ARM = 2'b01,
		TS_RUN = 2'b10
	} peq_tstate_t;
endpackage : peq_pkg

/* File: rtl/peq_counter.sv */
// Pulse counters, switch debounce, quadrature decoders and an edge timer behind AXI4-Lite.
// Assumes terminal inputs are asynchronous pins; one clock, async active-low reset.
`timescale 1ns/100ps
module peq_counter #(
	parameter int N_TERM = 12,
	parameter int DEB_CYC = peq_pkg::DEBOUNCE_CYC
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic [N_TERM-1:0] term_in,
	input wire logic [peq_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [peq_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic irq
);
	localparam int N_PAIR = N_TERM / 2;
	localparam int SEL_W = $clog2(N_TERM);
	localparam int DEB_W = $clog2(DEB_CYC + 1);
	localparam logic [DEB_W-1:0] DEB_LAST = DEB_W'(DEB_CYC - 1);
	localparam logic [31:0] MIN_EDGE = 32'(peq_pkg::MIN_EDGE_CYC);

	// Configuration and status
	logic ctrl_en;
	logic [31:0] scan_period;
	logic [N_TERM-1:0] sw_mask;
	logic [N_PAIR-1:0] quad_en;
	logic [2*N_PAIR-1:0] quad_mode;
	logic [peq_pkg::IRQ_W-1:0] irq_stat, irq_en, irq_ev;
	logic [SEL_W-1:0] tmr_sel;
	logic [1:0] tmr_mode;
	logic [31:0] tmr_timeout, tmr_result, tmr_cnt;
	logic tmr_nan, tmr_valid;
	peq_pkg::peq_tstate_t tmr_state;
	logic [31:0] scan_ctr, scan_count;
	logic scan_tick;

	// Terminal path
	logic [N_TERM-1:0] filt, fprev, inc;
	logic [31:0] cnt [N_TERM];
	logic [31:0] snap [N_TERM];
	logic [N_TERM-1:0] wrap;
	logic [N_PAIR-1:0] q_up, q_dn, q_dir;
	logic [31:0] q_net [N_PAIR];
	logic [31:0] q_fwd [N_PAIR];
	logic [31:0] q_rev [N_PAIR];

	// Bus side
	logic aw_full, w_full;
	logic [peq_pkg::ADDR_W-1:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic wr_en;

	typedef enum logic [1:0] {
		RK_NONE = 2'b00,
		RK_PULSE = 2'b01,
		RK_QUAD = 2'b10,
		RK_FIXED = 2'b11
	} peq_rkind_t;

	// Classifies a byte address; decode shared by read and write paths
	function automatic peq_rkind_t reg_kind(input logic [peq_pkg::ADDR_W-1:0] a);
		int ai;
		ai = int'(a);
		if (a[1:0] != 2'b00) begin
			return RK_NONE;
		end
		if (ai >= int'(peq_pkg::REG_PULSE_BASE) && ai < int'(peq_pkg::REG_PULSE_BASE) + 4 * N_TERM) begin
			return RK_PULSE;
		end
		if (ai >= int'(peq_pkg::REG_QUAD_BASE) &&
				ai < int'(peq_pkg::REG_QUAD_BASE) + peq_pkg::QUAD_STRIDE * N_PAIR) begin
			return RK_QUAD;
		end
		if (a <= peq_pkg::REG_SCAN_CNT) begin
			return RK_FIXED;
		end
		return RK_NONE;
	endfunction : reg_kind

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (s[b]) begin
				r[8*b +: 8] = d[8*b +: 8];
			end
		end
		return r;
	endfunction : merge

	function automatic logic [31:0] rd_word(input logic [peq_pkg::ADDR_W-1:0] a);
		int off;
		logic [31:0] r;
		r = 32'h0;
		unique case (reg_kind(a))
			RK_PULSE: begin
				off = (int'(a) - int'(peq_pkg::REG_PULSE_BASE)) / 4;
				r = snap[off];
			end
			RK_QUAD: begin
				off = int'(a) - int'(peq_pkg::REG_QUAD_BASE);
				unique case ((off % peq_pkg::QUAD_STRIDE) / 4)
					peq_pkg::QW_NET: r = q_net[off / peq_pkg::QUAD_STRIDE];
					peq_pkg::QW_FWD: r = q_fwd[off / peq_pkg::QUAD_STRIDE];
					peq_pkg::QW_REV: r = q_rev[off / peq_pkg::QUAD_STRIDE];
					default: r = {31'h0, q_dir[off / peq_pkg::QUAD_STRIDE]};
				endcase
			end
			RK_FIXED: begin
				unique case (a)
					peq_pkg::REG_CTRL: r = {31'h0, ctrl_en};
					peq_pkg::REG_SCAN_PERIOD: r = scan_period;
					peq_pkg::REG_SW_MASK: r = 32'(sw_mask);
					peq_pkg::REG_QUAD_EN: r = 32'(quad_en);
					peq_pkg::REG_QUAD_MODE: r = 32'(quad_mode);
					peq_pkg::REG_IRQ_STAT: r = 32'(irq_stat);
					peq_pkg::REG_IRQ_EN: r = 32'(irq_en);
					peq_pkg::REG_TMR_CFG: begin
						r[peq_pkg::TCFG_SEL_LSB +: SEL_W] = tmr_sel;
						r[peq_pkg::TCFG_MODE_LSB +: 2] = tmr_mode;
					end
					peq_pkg::REG_TMR_TIMEOUT: r = tmr_timeout;
					peq_pkg::REG_TMR_RESULT: r = tmr_result;
					peq_pkg::REG_TMR_STAT: begin
						r[peq_pkg::TSTAT_BUSY] = (tmr_state != peq_pkg::TS_IDLE);
						r[peq_pkg::TSTAT_NAN] = tmr_nan;
						r[peq_pkg::TSTAT_VALID] = tmr_valid;
					end
					peq_pkg::REG_SCAN_CNT: r = scan_count;
					default: r = 32'h0;
				endcase
			end
			default: r = 32'h0;
		endcase
		return r;
	endfunction : rd_word

	// Per-terminal synchroniser and debounce
	genvar gi;
	generate
		for (gi = 0; gi < N_TERM; gi++) begin : g_term
			logic s1, s2, f;
			logic [DEB_W-1:0] stab;
			always_ff @(posedge clock or negedge rst_n) begin
				if (!rst_n) begin
					s1 <= 1'b1;
					s2 <= 1'b1;
				end else if (ce) begin
					s1 <= term_in[gi];
					s2 <= s1;
				end
			end
			always_ff @(posedge clock or negedge rst_n) begin
				if (!rst_n) begin
					f <= 1'b1;
					stab <= '0;
				end else if (ce) begin
					if (!sw_mask[gi] || s2 == f) begin
						f <= s2;
						stab <= '0;
					end else if (stab == DEB_LAST) begin
						f <= s2;
						stab <= '0;
					end else begin
						stab <= stab + 1'b1;
					end
				end
			end
			assign filt[gi] = f;
			// Switch mode counts closures to ground, others count rising edges
			assign inc[gi] = ctrl_en & (sw_mask[gi] ? (fprev[gi] & ~f) : (~fprev[gi] & f));
		end
	endgenerate

	a_debounce_hold: assert property (@(posedge clock) disable iff (!rst_n)
		(ce && sw_mask[0] && g_term[0].s2 != filt[0] && g_term[0].stab == DEB_LAST)
		|=> filt[0] == $past(g_term[0].s2))
		else $error("debounced level not taken after hold time");
	a_debounce_block: assert property (@(posedge clock) disable iff (!rst_n)
		(ce && sw_mask[0] && g_term[0].stab != DEB_LAST) |=> $stable(filt[0]))
		else $error("debounced level moved before hold time");

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			fprev <= '1;
		end else if (ce) begin
			fprev <= filt;
		end
	end

	// Scan interval timer
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			scan_ctr <= '0;
			scan_tick <= 1'b0;
			scan_count <= '0;
		end else if (ce) begin
			scan_tick <= 1'b0;
			if (ctrl_en) begin
				if (scan_ctr >= scan_period - 32'h1) begin
					scan_ctr <= '0;
					scan_tick <= 1'b1;
					scan_count <= scan_count + 32'h1;
				end else begin
					scan_ctr <= scan_ctr + 32'h1;
				end
			end
		end
	end

	// Pulse accumulators
	always_comb begin
		for (int i = 0; i < N_TERM; i++) begin
			wrap[i] = inc[i] & ~scan_tick & (cnt[i] == 32'hFFFFFFFF);
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < N_TERM; i++) begin
				cnt[i] <= '0;
				snap[i] <= '0;
			end
		end else if (ce) begin
			for (int i = 0; i < N_TERM; i++) begin
				if (scan_tick) begin
					snap[i] <= cnt[i];
					cnt[i] <= {31'h0, inc[i]};
				end else if (inc[i]) begin
					cnt[i] <= cnt[i] + 32'h1;
				end
			end
		end
	end

	a_pulse_count: assert property (@(posedge clock) disable iff (!rst_n)
		(ce && inc[0] && !scan_tick) |=> cnt[0] == $past(cnt[0]) + 32'h1)
		else $error("pulse counter missed a count");
	a_scan_sample: assert property (@(posedge clock) disable iff (!rst_n)
		(ce && scan_tick) |=> (snap[0] == $past(cnt[0]) && cnt[0] <= 32'h1))
		else $error("scan did not sample and clear counter");
	a_wrap_flag: assert property (@(posedge clock) disable iff (!rst_n)
		(ce && wrap[0]) |=> (cnt[0] == 32'h0 && irq_stat[peq_pkg::IRQ_WRAP]))
		else $error("counter wrap not reported");

	// Quadrature decode, pair p uses terminals 2p (A) and 2p+1 (B)
	always_comb begin
		logic a, b, ar, af, br, bf;
		a = 1'b0;
		b = 1'b0;
		ar = 1'b0;
		af = 1'b0;
		br = 1'b0;
		bf = 1'b0;
		for (int p = 0; p < N_PAIR; p++) begin
			a = filt[2*p];
			b = filt[2*p+1];
			ar = a & ~fprev[2*p];
			af = ~a & fprev[2*p];
			br = b & ~fprev[2*p+1];
			bf = ~b & fprev[2*p+1];
			unique case (quad_mode[2*p +: 2])
				peq_pkg::QM_A_RISE: begin
					q_up[p] = ar & ~b;
					q_dn[p] = af & ~b;
				end
				peq_pkg::QM_A_BOTH: begin
					q_up[p] = (ar & ~b) | (af & b);
					q_dn[p] = (ar & b) | (af & ~b);
				end
				default: begin
					q_up[p] = (ar & ~b) | (af & b) | (br & a) | (bf & ~a);
					q_dn[p] = (ar & b) | (af & ~b) | (br & ~a) | (bf & a);
				end
			endcase
			q_up[p] = q_up[p] & quad_en[p] & ctrl_en;
			q_dn[p] = q_dn[p] & quad_en[p] & ctrl_en;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			q_dir <= '0;
			for (int p = 0; p < N_PAIR; p++) begin
				q_net[p] <= '0;
				q_fwd[p] <= '0;
				q_rev[p] <= '0;
			end
		end else if (ce) begin
			for (int p = 0; p < N_PAIR; p++) begin
				if (q_up[p] && !q_dn[p]) begin
					q_net[p] <= q_net[p] + 32'h1;
					q_fwd[p] <= q_fwd[p] + 32'h1;
					q_dir[p] <= 1'b1;
				end else if (q_dn[p] && !q_up[p]) begin
					q_net[p] <= q_net[p] - 32'h1;
					q_rev[p] <= q_rev[p] + 32'h1;
					q_dir[p] <= 1'b0;
				end
			end
		end
	end

	a_quad_up: assert property (@(posedge clock) disable iff (!rst_n)
		(ce && q_up[0] && !q_dn[0]) |=> (q_net[0] == $past(q_net[0]) + 32'h1 && q_dir[0]))
		else $error("forward step did not raise net count");
	a_quad_down: assert property (@(posedge clock) disable iff (!rst_n)
		(ce && q_dn[0] && !q_up[0]) |=> (q_net[0] == $past(q_net[0]) - 32'h1 && !q_dir[0]))
		else $error("reverse step did not lower net count");

	// Edge timer; result in clock cycles
	logic [SEL_W-1:0] prev_sel;
	logic sel_any, sel_rise, prev_any, tmr_start, tmr_hit_to;
	assign prev_sel = (tmr_sel == '0) ? SEL_W'(N_TERM - 1) : tmr_sel - 1'b1;
	assign sel_any = filt[tmr_sel] ^ fprev[tmr_sel];
	assign sel_rise = filt[tmr_sel] & ~fprev[tmr_sel];
	assign prev_any = filt[prev_sel] ^ fprev[prev_sel];
	assign tmr_start = wr_en && aw_addr == peq_pkg::REG_CTRL && w_strb[0] && w_data[peq_pkg::CTRL_TSTART_BIT];
	assign tmr_hit_to = tmr_cnt >= tmr_timeout;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			tmr_state <= peq_pkg::TS_IDLE;
			tmr_cnt <= '0;
			tmr_result <= '0;
			tmr_nan <= 1'b0;
			tmr_valid <= 1'b0;
		end else if (ce) begin
			unique case (tmr_state)
				peq_pkg::TS_IDLE: begin
					if (tmr_start) begin
						tmr_cnt <= '0;
						tmr_valid <= 1'b0;
						tmr_nan <= 1'b0;
						if (tmr_mode == peq_pkg::TM_PERIOD || tmr_mode == peq_pkg::TM_PREV) begin
							tmr_state <= peq_pkg::TS_ARM;
						end else begin
							tmr_state <= peq_pkg::TS_RUN;
						end
					end
				end
				peq_pkg::TS_ARM: begin
					if (tmr_hit_to) begin
						tmr_nan <= 1'b1;
						tmr_valid <= 1'b1;
						tmr_state <= peq_pkg::TS_IDLE;
					end else if ((tmr_mode == peq_pkg::TM_PERIOD && sel_rise) ||
							(tmr_mode == peq_pkg::TM_PREV && prev_any)) begin
						tmr_cnt <= '0;
						tmr_state <= peq_pkg::TS_RUN;
					end else begin
						tmr_cnt <= tmr_cnt + 32'h1;
					end
				end
				peq_pkg::TS_RUN: begin
					if (tmr_hit_to) begin
						tmr_nan <= 1'b1;
						tmr_valid <= 1'b1;
						tmr_state <= peq_pkg::TS_IDLE;
					end else if ((tmr_mode == peq_pkg::TM_PERIOD) ? sel_rise : sel_any) begin
						tmr_result <= tmr_cnt;
						tmr_nan <= (tmr_mode != peq_pkg::TM_SINGLE) && (tmr_cnt < MIN_EDGE);
						tmr_valid <= 1'b1;
						tmr_state <= peq_pkg::TS_IDLE;
					end else begin
						tmr_cnt <= tmr_cnt + 32'h1;
					end
				end
				default: tmr_state <= peq_pkg::TS_IDLE;
			endcase
		end
	end

	a_timer_expire: assert property (@(posedge clock) disable iff (!rst_n)
		(ce && tmr_state != peq_pkg::TS_IDLE && tmr_hit_to) |=> (tmr_nan && tmr_state == peq_pkg::TS_IDLE))
		else $error("expired timer did not give not-a-number");

	// Interrupts: set wins over clear
	always_comb begin
		irq_ev = '0;
		irq_ev[peq_pkg::IRQ_SCAN] = ce & scan_tick;
		irq_ev[peq_pkg::IRQ_TDONE] = ce & (tmr_state != peq_pkg::TS_IDLE) & ~tmr_hit_to &
			((tmr_state == peq_pkg::TS_RUN) & ((tmr_mode == peq_pkg::TM_PERIOD) ? sel_rise : sel_any));
		irq_ev[peq_pkg::IRQ_TNAN] = ce & (tmr_state != peq_pkg::TS_IDLE) & tmr_hit_to;
		irq_ev[peq_pkg::IRQ_WRAP] = ce & (|wrap);
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			irq_stat <= '0;
			irq <= 1'b0;
		end else if (ce) begin
			if (wr_en && aw_addr == peq_pkg::REG_IRQ_CLR) begin
				irq_stat <= (irq_stat & ~w_data[peq_pkg::IRQ_W-1:0]) | irq_ev;
			end else begin
				irq_stat <= irq_stat | irq_ev;
			end
			irq <= |(irq_stat & irq_en);
		end
	end

	// Register writes
	assign wr_en = aw_full & w_full & ~s_axi_bvalid;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_en <= 1'b0;
			scan_period <= peq_pkg::SCAN_PERIOD_RST;
			sw_mask <= '0;
			quad_en <= '0;
			quad_mode <= '0;
			irq_en <= '0;
			tmr_sel <= '0;
			tmr_mode <= peq_pkg::TM_SINGLE;
			tmr_timeout <= peq_pkg::TMR_TIMEOUT_RST;
		end else if (ce && wr_en) begin
			unique case (aw_addr)
				peq_pkg::REG_CTRL: begin
					if (w_strb[0]) begin
						ctrl_en <= w_data[peq_pkg::CTRL_EN_BIT];
					end
				end
				peq_pkg::REG_SCAN_PERIOD: scan_period <= merge(scan_period, w_data, w_strb);
				peq_pkg::REG_SW_MASK: sw_mask <= N_TERM'(merge(32'(sw_mask), w_data, w_strb));
				peq_pkg::REG_QUAD_EN: quad_en <= N_PAIR'(merge(32'(quad_en), w_data, w_strb));
				peq_pkg::REG_QUAD_MODE: quad_mode <= (2*N_PAIR)'(merge(32'(quad_mode), w_data, w_strb));
				peq_pkg::REG_IRQ_EN: irq_en <= peq_pkg::IRQ_W'(merge(32'(irq_en), w_data, w_strb));
				peq_pkg::REG_TMR_CFG: begin
					if (w_strb[0] && tmr_state == peq_pkg::TS_IDLE) begin
						tmr_sel <= w_data[peq_pkg::TCFG_SEL_LSB +: SEL_W];
						tmr_mode <= w_data[peq_pkg::TCFG_MODE_LSB +: 2];
					end
				end
				peq_pkg::REG_TMR_TIMEOUT: tmr_timeout <= merge(tmr_timeout, w_data, w_strb);
				default: ;
			endcase
		end
	end

	// AXI4-Lite handshakes, one write and one read at a time
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= peq_pkg::RESP_OKAY;
			aw_full <= 1'b0;
			w_full <= 1'b0;
			aw_addr <= '0;
			w_data <= '0;
			w_strb <= '0;
		end else if (ce) begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_full <= 1'b1;
				aw_addr <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_full <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (wr_en) begin
				aw_full <= 1'b0;
				w_full <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (reg_kind(aw_addr) == RK_FIXED) ? peq_pkg::RESP_OKAY : peq_pkg::RESP_SLVERR;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= peq_pkg::RESP_OKAY;
		end else if (ce) begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_word(s_axi_araddr);
				s_axi_rresp <= (reg_kind(s_axi_araddr) == RK_NONE) ? peq_pkg::RESP_SLVERR : peq_pkg::RESP_OKAY;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end
endmodule : peq_counter

/* File: verif/peq_sensor.sv */
// Sensor model: pulse, switch-closure and encoder sources on the terminal pins.
// Assumes the bench calls its tasks after a clock edge; pins idle high.
`timescale 1ns/100ps
module peq_sensor #(
	parameter int N = 12
) (
	input wire logic clock,
	output logic [N-1:0] pins
);
	logic [1:0] ph;
	initial begin
		pins = '1;
		ph = 2'h2;
	end
	task automatic pulse(input int t, input int n, input int w);
		repeat (n) begin
			repeat (w) @(posedge clock);
			pins[t] <= 1'b0;
			repeat (w) @(posedge clock);
			pins[t] <= 1'b1;
		end
	endtask : pulse
	// Contact chatter of one-cycle spikes, then a settled level
	task automatic bounce(input int t, input logic s);
		repeat (3) begin
			@(posedge clock);
			pins[t] <= s;
			@(posedge clock);
			pins[t] <= ~s;
		end
		@(posedge clock);
		pins[t] <= s;
		repeat (30) @(posedge clock);
	endtask : bounce
	// Gray steps on pair p; forward means A leads B
	task automatic quad(input int p, input int n, input logic fwd);
		repeat (n) begin
			repeat (6) @(posedge clock);
			ph = fwd ? ph + 2'h1 : ph - 2'h1;
			pins[2 * p] <= ph[1] ^ ph[0];
			pins[2 * p + 1] <= ph[1];
		end
	endtask : quad
endmodule : peq_sensor

/* File: verif/testbench.sv */
// Bench: register-level tests of the pulse, edge and quadrature counter over AXI4-Lite.
// Assumes the sensor model drives all terminal pins; one 50 MHz clock.
`timescale 1ns/100ps
module testbench;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic ce_in = 1'b1;
	logic [7:0] awa = 8'h00, ara = 8'h00;
	logic awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0;
	logic [31:0] wd = 32'h0;
	logic awr, wrd, bv, arr, rv, irq;
	logic [1:0] br, rr, rs;
	logic [31:0] rdat, v, f0, r0, n0, k;
	logic [11:0] pins;
	int fail_count = 0;
	int n_tests = 0;
	peq_counter #(.DEB_CYC(6)) u_peq_counter (.clock(clock), .rst_n(rst_n), .ce(ce_in), .term_in(pins),
		.s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF),
		.s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bre),
		.s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rr),
		.s_axi_rvalid(rv), .s_axi_rready(rre), .irq(irq));
	// Terminals 0 and 1 serve the switch and pulse tests, then quadrature pair 0
	peq_sensor u_peq_sensor (.clock(clock), .pins(pins));
	initial begin
		forever #10 clock = ~clock;
	end
	task automatic cyc(input int n);
		repeat (n) @(posedge clock);
	endtask : cyc
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		awa <= a;
		wd <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		bre <= 1'b1;
		do begin
			@(posedge clock);
			if (awr) awv <= 1'b0;
			if (wrd) wv <= 1'b0;
		end while (!bv);
		chk("bresp", 32'h0, 32'(br));
	endtask : wr
	task automatic rd(input logic [7:0] a);
		ara <= a;
		arv <= 1'b1;
		rre <= 1'b1;
		do begin
			@(posedge clock);
			if (arr) arv <= 1'b0;
		end while (!rv);
		v = rdat;
		rs = rr;
	endtask : rd
	task automatic exp(input string n, input logic [7:0] a, input logic [31:0] e);
		rd(a);
		chk(n, e, v);
		chk("rresp", 32'h0, 32'(rs));
	endtask : exp
	task automatic wait_irq();
		wr(peq_pkg::REG_IRQ_CLR, 32'h1);
		cyc(3);
		while (irq !== 1'b1) @(posedge clock);
	endtask : wait_irq
	function automatic logic [7:0] pb(input int i);
		return 8'(peq_pkg::REG_PULSE_BASE + 4 * i);
	endfunction : pb
	function automatic logic [7:0] qa(input int w);
		return 8'(peq_pkg::REG_QUAD_BASE + 4 * w);
	endfunction : qa
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : print_verdict
	initial begin
		cyc(20000);
		fail_count++;
		print_verdict();
	end
	initial begin
		cyc(3);
		rst_n <= 1'b1;
		@(posedge clock);
		exp("scan_period", peq_pkg::REG_SCAN_PERIOD, peq_pkg::SCAN_PERIOD_RST);
		exp("tmr_timeout", peq_pkg::REG_TMR_TIMEOUT, peq_pkg::TMR_TIMEOUT_RST);
		exp("irq_stat", peq_pkg::REG_IRQ_STAT, 32'h0);
		rd(8'h3C);
		chk("rresp", 32'h2, 32'(rs));
		$display("test reset done");
		wr(peq_pkg::REG_SCAN_PERIOD, 32'h190);
		wr(peq_pkg::REG_SW_MASK, 32'h1);
		wr(peq_pkg::REG_IRQ_EN, 32'h1);
		wr(peq_pkg::REG_CTRL, 32'h1);
		wait_irq();
		fork
			u_peq_sensor.pulse(1, 5, 3);
			begin
				u_peq_sensor.bounce(0, 1'b0);
				u_peq_sensor.bounce(0, 1'b1);
				u_peq_sensor.pulse(0, 2, 3);
			end
		join
		wait_irq();
		exp("pulse1", pb(1), 32'h5);
		exp("pulse0", pb(0), 32'h1);
		exp("pulse2", pb(2), 32'h0);
		wait_irq();
		exp("pulse1", pb(1), 32'h0);
		exp("scan_cnt", peq_pkg::REG_SCAN_CNT, 32'h3);
		$display("test scan done");
		wr(peq_pkg::REG_IRQ_EN, 32'h0);
		cyc(450);
		chk("irq", 32'h0, 32'(irq));
		wr(peq_pkg::REG_CTRL, 32'h0);
		exp("irq_stat", peq_pkg::REG_IRQ_STAT, 32'h1);
		wr(peq_pkg::REG_IRQ_CLR, 32'h1);
		exp("irq_stat", peq_pkg::REG_IRQ_STAT, 32'h0);
		$display("test irq done");
		wr(peq_pkg::REG_CTRL, 32'h1);
		rd(peq_pkg::REG_SCAN_CNT);
		n0 = v;
		ce_in <= 1'b0;
		cyc(900);
		ce_in <= 1'b1;
		rd(peq_pkg::REG_SCAN_CNT);
		chk("ce_freeze", 32'h1, 32'(v - n0 <= 32'h1));
		$display("test clock enable done");
		wr(peq_pkg::REG_SW_MASK, 32'h0);
		wr(peq_pkg::REG_QUAD_EN, 32'h1);
		for (int m = 0; m < 3; m++) begin
			k = 32'h1 << m;
			wr(peq_pkg::REG_QUAD_MODE, 32'(m));
			rd(qa(peq_pkg::QW_NET));
			n0 = v;
			rd(qa(peq_pkg::QW_FWD));
			f0 = v;
			rd(qa(peq_pkg::QW_REV));
			r0 = v;
			u_peq_sensor.quad(0, 8, 1'b1);
			cyc(8);
			exp("quad_fwd", qa(peq_pkg::QW_FWD), f0 + (k << 1));
			exp("quad_dir", qa(peq_pkg::QW_DIR), 32'h1);
			u_peq_sensor.quad(0, 4, 1'b0);
			cyc(8);
			exp("quad_rev", qa(peq_pkg::QW_REV), r0 + k);
			exp("quad_net", qa(peq_pkg::QW_NET), n0 + k);
			exp("quad_dir", qa(peq_pkg::QW_DIR), 32'h0);
		end
		$display("test quadrature done");
		wr(peq_pkg::REG_TMR_TIMEOUT, 32'h64);
		wr(peq_pkg::REG_TMR_CFG, 32'h3);
		wr(peq_pkg::REG_CTRL, 32'h3);
		cyc(150);
		exp("tmr_stat", peq_pkg::REG_TMR_STAT, 32'h6);
		wr(peq_pkg::REG_CTRL, 32'h3);
		u_peq_sensor.pulse(3, 1, 20);
		cyc(10);
		exp("tmr_stat", peq_pkg::REG_TMR_STAT, 32'h4);
		rd(peq_pkg::REG_TMR_RESULT);
		chk("tmr_result", 32'h1, 32'(v > 15 && v < 35));
		wr(peq_pkg::REG_TMR_CFG, 32'h13);
		wr(peq_pkg::REG_CTRL, 32'h3);
		u_peq_sensor.pulse(3, 3, 2);
		cyc(10);
		exp("tmr_stat", peq_pkg::REG_TMR_STAT, 32'h6);
		wr(peq_pkg::REG_TMR_CFG, 32'h23);
		wr(peq_pkg::REG_CTRL, 32'h3);
		fork
			u_peq_sensor.pulse(2, 1, 4);
			u_peq_sensor.pulse(3, 1, 20);
		join
		cyc(10);
		exp("tmr_stat", peq_pkg::REG_TMR_STAT, 32'h4);
		rd(peq_pkg::REG_TMR_RESULT);
		chk("tmr_prev", 32'h1, 32'(v > 10 && v < 20));
		$display("test timer done");
		print_verdict();
	end
endmodule : testbench
